//--- rtl/fifle_cfg.svh
// Offsets, field positions, reset values and timing counts of the input block.
// Assumes a 100 MHz core clock and a byte-addressed register bus.
`ifndef FIFLE_CFG_SVH
`define FIFLE_CFG_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define FIFLE_OFS_CTRL    8'h00
`define FIFLE_OFS_LATCH   8'h04
`define FIFLE_OFS_EVEN    8'h08
`define FIFLE_OFS_EVMODE  8'h0c
`define FIFLE_OFS_INPUT   8'h10
`define FIFLE_OFS_STATUS  8'h14
`define FIFLE_OFS_EVENT   8'h18
`define FIFLE_OFS_EVNUM   8'h40
// ****************************************
// Field positions
// ****************************************
`define FIFLE_CTRL_MODE   0
`define FIFLE_CTRL_FLT_LO 1
`define FIFLE_CTRL_FLT_HI 4
`define FIFLE_CTRL_CLEAR  31
`define FIFLE_EVT_VALID   31
`define FIFLE_EVT_RISE    8
// ****************************************
// Reset values and timing
// ****************************************
`define FIFLE_FLT_RESET   4'h8
`define FIFLE_CLK_MHZ     100
`define FIFLE_TICK_US     100
`define FIFLE_HALF_MS_TKS 5
`define FIFLE_FLASH_MS    250
`endif

//--- rtl/fifle_filt_if.sv
// Bundle between the top block and its debounce filter.
// Assumes both ends run on the same core clock.
`default_nettype none
interface fifle_filt_if #(parameter int NCH = 16);
  logic                 tick;   // 0.1 ms enable pulse
  fifle_pkg::fifle_limit_t limit; // Ticks a level must hold
  logic [NCH-1:0]       raw;    // Synchronised pin levels
  logic [NCH-1:0]       filt;   // Debounced levels
  modport top (output tick, output limit, output raw, input filt);
  modport flt (input tick, input limit, input raw, output filt);
endinterface : fifle_filt_if
`default_nettype wire

//--- rtl/fifle_filter.sv
// Per-channel debounce counters for the fast input block.
// Assumes raw inputs are already synchronised to the core clock.
`default_nettype none
module fifle_filter #(
  parameter int NCH = 16
) (
  input  wire logic  i_core_clk,
  input  wire logic  i_rst_b,
  fifle_filt_if.flt  flt
);
  import fifle_pkg::*;

  // ****************************************
  // Debounce counters
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      fifle_limit_t cnt_reg;  // Ticks the new level has held
      // Count only while raw differs; any return restarts the wait
      always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          cnt_reg <= '0;
        end else if (flt.raw[g] == flt.filt[g]) begin
          cnt_reg <= '0;
        end else if (flt.tick) begin
          if (cnt_reg + 7'h01 >= flt.limit) begin
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 7'h01;
          end
        end
      end
      // Pass the level once held for the full time
      always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          flt.filt[g] <= 1'b0;
        end else if (flt.tick && flt.raw[g] != flt.filt[g] &&
                     cnt_reg + 7'h01 >= flt.limit) begin
          flt.filt[g] <= flt.raw[g];
        end
      end
    end
  endgenerate
endmodule : fifle_filter
`default_nettype wire

//--- rtl/fifle_pkg.sv
// Types shared by the fast input filter, latch and event block.
// Assumes the constants header is on the include path.
`default_nettype none
package fifle_pkg;
  typedef logic [5:0] fifle_evnum_t;   // Handler index
  typedef logic [6:0] fifle_limit_t;   // Filter length in 0.1 ms ticks
  typedef enum logic {FIFLE_BUS_IDLE, FIFLE_BUS_ACK} fifle_bus_st_t;
endpackage : fifle_pkg
`default_nettype wire

//--- rtl/fifle_top.sv
// Fast discrete input block: filter, pulse latch, event inputs, diagnostics.
// Assumes an Avalon-MM master on the core clock and asynchronous pins.
//
// Operation
// - Filter 0.1 ms, or 0.5 to 7.5 ms
// - Default filter time is four milliseconds
// - Filter changes accepted only in configuration mode
// - Latch filtered change in chosen direction
// - Latched pulse shown next read, no interrupt
// - Any channel can be an event input
// - Event number zero only on channel zero
// - Event handler index zero to 31 or 63
// - Rising, falling or either edge, edge reported
// - Simultaneous events delivered lowest channel first
// - Bus fault flashes lamp, sets module fault
// - Internal fault: fault lamp on, healthy off
// - Low sensor supply: lamp, flags, fault codes
// - Supply fault forces all channels to fault
// - Missing terminal block flashes lamp, reported
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
`include "fifle_cfg.svh"
`default_nettype none
module fifle_top #(
  parameter int NCH       = 16,
  parameter int EVT_MAX   = 63,
  parameter int TICK_CYC  = `FIFLE_TICK_US * `FIFLE_CLK_MHZ,
  parameter int FLASH_CYC = `FIFLE_FLASH_MS * 1000 * `FIFLE_CLK_MHZ
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output var  logic [31:0] o_avs_readdata,
  output var  logic        o_avs_waitrequest,
  input  wire logic [15:0] i_din,
  input  wire logic        i_bus_fault,
  input  wire logic        i_int_fault,
  input  wire logic        i_sensor_low,
  input  wire logic        i_tblock_present,
  output var  logic        o_event_req,
  output var  logic        o_lamp_err,
  output var  logic        o_lamp_run,
  output var  logic        o_lamp_io
);
  import fifle_pkg::*;

  // Elaboration checks
  if (NCH != 16) begin : g_bad_nch
    $error("fifle_top serves exactly sixteen channels");
  end
  if (EVT_MAX != 31 && EVT_MAX != 63) begin : g_bad_evt
    $error("fifle_top event range must be 31 or 63");
  end
  if (TICK_CYC < 2 || FLASH_CYC < 2) begin : g_bad_cyc
    $error("fifle_top tick counts too small");
  end

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic       rst_m_reg;   // First reset stage
  logic       rst_b_reg;   // Released reset for the core
  logic [19:0] pin_m_reg;  // First pin stage, read only by stage two
  logic [19:0] pin_s_reg;  // Second pin stage

  // Assert at once, release after two edges
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_m_reg <= 1'b0;
      rst_b_reg <= 1'b0;
    end else begin
      rst_m_reg <= 1'b1;
      rst_b_reg <= rst_m_reg;
    end
  end

  // Two-stage capture of every asynchronous pin
  always_ff @(posedge i_core_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      pin_m_reg <= '0;
      pin_s_reg <= '0;
    end else begin
      pin_m_reg <= {i_tblock_present, i_sensor_low, i_int_fault, i_bus_fault, i_din};
      pin_s_reg <= pin_m_reg;
    end
  end

  logic bus_flt;   // Backplane dialog fault
  logic int_flt;   // Internal fault
  logic sens_low;  // Sensor supply at or below threshold
  logic tb_miss;   // Terminal block absent or loose
  assign bus_flt  = pin_s_reg[16];
  assign int_flt  = pin_s_reg[17];
  assign sens_low = pin_s_reg[18];
  assign tb_miss  = ~pin_s_reg[19];

  // ****************************************
  // Tick and flash dividers
  // ****************************************
  logic [31:0] tick_cnt_reg;   // 0.1 ms divider
  logic        tick;           // One-cycle enable pulse
  logic [31:0] flash_cnt_reg;  // Lamp blink divider
  logic        flash_reg;      // Blink phase

  assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

  // Free-running base tick for the filter
  always_ff @(posedge i_core_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end

  // Blink phase toggles every flash period
  always_ff @(posedge i_core_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      flash_cnt_reg <= '0;
      flash_reg     <= 1'b0;
    end else if (flash_cnt_reg == 32'(FLASH_CYC - 1)) begin
      flash_cnt_reg <= '0;
      flash_reg     <= ~flash_reg;
    end else begin
      flash_cnt_reg <= flash_cnt_reg + 32'h1;
    end
  end

  // ****************************************
  // Bus slave handshake
  // ****************************************
  fifle_bus_st_t bus_st_reg;  // Idle or answering
  logic          req;         // Request present
  logic          done;        // Edge at which the access completes
  logic          wr_go;       // Write takes effect now
  logic          rd_go;       // Read side effects now

  assign req  = i_avs_read | i_avs_write;
  assign done = req && bus_st_reg == FIFLE_BUS_ACK;
  assign wr_go = done & i_avs_write;
  assign rd_go = done & i_avs_read;
  // One wait cycle so read data is registered before release
  assign o_avs_waitrequest = req && bus_st_reg != FIFLE_BUS_ACK;

  // Two-cycle access sequence
  always_ff @(posedge i_core_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      bus_st_reg <= FIFLE_BUS_IDLE;
    end else begin
      case (bus_st_reg)
        FIFLE_BUS_IDLE: bus_st_reg <= req ? FIFLE_BUS_ACK : FIFLE_BUS_IDLE;
        FIFLE_BUS_ACK:  bus_st_reg <= FIFLE_BUS_IDLE;
        default:        bus_st_reg <= FIFLE_BUS_IDLE;
      endcase
    end
  end

  // Byte-lane merge for 32-bit registers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // ****************************************
  // Configuration registers
  // ****************************************
  logic         cfg_mode_reg;          // Configuration mode
  logic [3:0]   flt_code_reg;          // 0: 0.1 ms, n: n x 0.5 ms
  logic [31:0]  latch_reg;             // [15:0] enable, [31:16] rising
  logic [15:0]  ev_en_reg;             // Event input enable
  logic [31:0]  ev_mode_reg;           // Two bits per channel
  fifle_evnum_t ev_num_reg [NCH];      // Handler index per channel
  logic         cfg_wr;                // Config write allowed
  logic [31:0]  ctrl_new;              // Merged control word
  logic         ev_sel;                // Address hits index block
  logic [3:0]   ev_ch;                 // Channel of index write

  assign cfg_wr   = wr_go & cfg_mode_reg;
  assign ctrl_new = be_merge({27'h0, flt_code_reg, cfg_mode_reg},
                             i_avs_writedata, i_avs_byteenable);
  assign ev_sel   = (i_avs_address[7:6] == 2'h1) && (i_avs_address[1:0] == 2'h0);
  assign ev_ch    = i_avs_address[5:2];

  // Mode bit and filter code; filter default restored on clear in configuration mode
  always_ff @(posedge i_core_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      cfg_mode_reg <= 1'b0;
      flt_code_reg <= `FIFLE_FLT_RESET;
    end else if (wr_go && i_avs_address == `FIFLE_OFS_CTRL) begin
      cfg_mode_reg <= ctrl_new[`FIFLE_CTRL_MODE];
      if (cfg_mode_reg && ctrl_new[`FIFLE_CTRL_CLEAR]) begin
        flt_code_reg <= `FIFLE_FLT_RESET;
      end else if (cfg_mode_reg) begin
        flt_code_reg <= ctrl_new[`FIFLE_CTRL_FLT_HI:`FIFLE_CTRL_FLT_LO];
      end
    end
  end

  // Latch and event setup, writable in configuration mode only
  always_ff @(posedge i_core_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      latch_reg   <= '0;
      ev_en_reg   <= '0;
      ev_mode_reg <= '0;
    end else if (cfg_wr) begin
      case (i_avs_address)
        `FIFLE_OFS_LATCH: latch_reg <= be_merge(latch_reg, i_avs_writedata, i_avs_byteenable);
        `FIFLE_OFS_EVEN:  ev_en_reg <= 16'(be_merge({16'h0, ev_en_reg},
                                          i_avs_writedata, i_avs_byteenable));
        `FIFLE_OFS_EVMODE: ev_mode_reg <= be_merge(ev_mode_reg, i_avs_writedata,
                                                   i_avs_byteenable);
        default: ;  // Other offsets leave setup alone
      endcase
    end
  end

  // Handler indices; out-of-range or forbidden zero keeps old value
  always_ff @(posedge i_core_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      for (int c = 0; c < NCH; c++) begin
        ev_num_reg[c] <= 6'(c);
      end
    end else if (cfg_wr && ev_sel && i_avs_byteenable[0]) begin
      if (i_avs_writedata[7:0] > 8'(EVT_MAX)) begin
        ev_num_reg[ev_ch] <= ev_num_reg[ev_ch];
      end else if (i_avs_writedata[5:0] == 6'h00 && ev_ch != 4'h0) begin
        ev_num_reg[ev_ch] <= ev_num_reg[ev_ch];
      end else begin
        ev_num_reg[ev_ch] <= i_avs_writedata[5:0];
      end
    end
  end

  // ****************************************
  // Input filter
  // ****************************************
  fifle_filt_if #(.NCH(NCH)) filt_bus ();
  logic [15:0] filt_q_reg;   // Filtered level one cycle ago
  logic [15:0] rise;         // Filtered rising edges
  logic [15:0] fall;         // Filtered falling edges

  assign filt_bus.tick  = tick;
  // 0.1 ms minimum, otherwise code times five 0.1 ms ticks
  assign filt_bus.limit = (flt_code_reg == 4'h0) ? 7'h01 :
                          7'(flt_code_reg * `FIFLE_HALF_MS_TKS);
  assign filt_bus.raw   = pin_s_reg[15:0];

  fifle_filter #(.NCH(NCH)) u_filter (
    .i_core_clk (i_core_clk),
    .i_rst_b    (rst_b_reg),
    .flt        (filt_bus.flt)
  );

  // Edge reference for latch and events
  always_ff @(posedge i_core_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      filt_q_reg <= '0;
    end else begin
      filt_q_reg <= filt_bus.filt;
    end
  end

  assign rise = filt_bus.filt & ~filt_q_reg;
  assign fall = ~filt_bus.filt & filt_q_reg;

  // ****************************************
  // Pulse latch
  // ****************************************
  logic [15:0] lat_hold_reg;  // Captured pulses awaiting a read
  logic [15:0] lat_shown_reg; // Pulses placed in the last read data
  logic [15:0] lat_set;       // New captures this cycle
  logic [15:0] in_view;       // Input word as the host sees it

  assign lat_set = latch_reg[15:0] &
                   ((latch_reg[31:16] & rise) | (~latch_reg[31:16] & fall));

  // Set wins over the read clear; never feeds the event request
  always_ff @(posedge i_core_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      lat_hold_reg <= '0;
    end else if (rd_go && i_avs_address == `FIFLE_OFS_INPUT) begin
      lat_hold_reg <= (lat_hold_reg & ~lat_shown_reg) | lat_set;
    end else begin
      lat_hold_reg <= lat_hold_reg | lat_set;
    end
  end

  // Captured pulse overrides the live level in its own direction
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      if (sens_low) begin
        in_view[c] = 1'b0;
      end else if (latch_reg[16+c]) begin
        in_view[c] = filt_bus.filt[c] | lat_hold_reg[c];
      end else begin
        in_view[c] = filt_bus.filt[c] & ~lat_hold_reg[c];
      end
    end
  end

  // ****************************************
  // Event inputs
  // ****************************************
  logic [15:0] ev_pend_reg;   // Pending events
  logic [15:0] ev_rise_reg;   // Edge kind per channel, 1 = rising
  logic [15:0] ev_hit;        // Configured edges this cycle
  logic [15:0] ev_pop;        // Channel taken by an event read
  logic [3:0]  ev_pop_ch_reg; // Channel placed in read data
  logic        ev_pop_v_reg;  // Read data held a valid event
  logic [3:0]  ev_first;      // Lowest pending channel
  logic        ev_any;        // Some event pending

  // Mode 01 rising, 10 falling, 11 either edge
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ev_hit[c] = ev_en_reg[c] & ((ev_mode_reg[2*c] & rise[c]) |
                                  (ev_mode_reg[2*c+1] & fall[c]));
    end
  end

  // Lowest channel wins when several are pending
  always_comb begin
    ev_first = 4'h0;
    ev_any   = 1'b0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (ev_pend_reg[c]) begin
        ev_first = 4'(c);
        ev_any   = 1'b1;
      end
    end
  end

  assign ev_pop = (rd_go && i_avs_address == `FIFLE_OFS_EVENT && ev_pop_v_reg) ?
                  (16'h0001 << ev_pop_ch_reg) : 16'h0000;

  // A new edge in the pop cycle keeps the event pending
  always_ff @(posedge i_core_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      ev_pend_reg <= '0;
    end else begin
      ev_pend_reg <= (ev_pend_reg & ~ev_pop) | ev_hit;
    end
  end

  // Record which edge fired for either-edge handlers
  always_ff @(posedge i_core_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      ev_rise_reg <= '0;
    end else begin
      ev_rise_reg <= (ev_rise_reg & ~ev_hit) | (ev_hit & rise);
    end
  end

  assign o_event_req = |ev_pend_reg;

  // ****************************************
  // Diagnostics and lamps
  // ****************************************
  logic [3:0]  mod_stat;   // Module status word
  logic [15:0] ch_fault;   // Channel fault flags

  assign mod_stat = {tb_miss, sens_low, int_flt, bus_flt};
  assign ch_fault = {16{sens_low}};

  // Lamps held in flops so they are glitch free
  always_ff @(posedge i_core_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      o_lamp_err <= 1'b0;
      o_lamp_run <= 1'b0;
      o_lamp_io  <= 1'b0;
    end else begin
      o_lamp_err <= int_flt | (bus_flt & flash_reg);
      o_lamp_run <= ~int_flt;
      o_lamp_io  <= sens_low | (tb_miss & flash_reg);
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Captured in the wait cycle; side effects use the same snapshot
  always_ff @(posedge i_core_clk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      o_avs_readdata <= '0;
      lat_shown_reg  <= '0;
      ev_pop_ch_reg  <= '0;
      ev_pop_v_reg   <= 1'b0;
    end else if (i_avs_read && bus_st_reg == FIFLE_BUS_IDLE) begin
      lat_shown_reg <= lat_hold_reg;
      ev_pop_ch_reg <= ev_first;
      ev_pop_v_reg  <= ev_any && i_avs_address == `FIFLE_OFS_EVENT;
      if (ev_sel) begin
        o_avs_readdata <= {26'h0, ev_num_reg[ev_ch]};
      end else begin
        case (i_avs_address)
          `FIFLE_OFS_CTRL:   o_avs_readdata <= {27'h0, flt_code_reg, cfg_mode_reg};
          `FIFLE_OFS_LATCH:  o_avs_readdata <= latch_reg;
          `FIFLE_OFS_EVEN:   o_avs_readdata <= {16'h0, ev_en_reg};
          `FIFLE_OFS_EVMODE: o_avs_readdata <= ev_mode_reg;
          `FIFLE_OFS_INPUT:  o_avs_readdata <= {16'h0, in_view};
          `FIFLE_OFS_STATUS: o_avs_readdata <= {ch_fault, 12'h0, mod_stat};
          `FIFLE_OFS_EVENT:  o_avs_readdata <= {ev_any, 9'h0, ev_num_reg[ev_first],
                                                7'h0, ev_rise_reg[ev_first],
                                                4'h0, ev_first};
          default:           o_avs_readdata <= 32'h0;  // Unmapped reads as zero
        endcase
      end
    end
  end
endmodule : fifle_top
`default_nettype wire

//--- test/fifle_host.sv
// Host model: Avalon-MM master standing in for the controller processor.
// Assumes one bus cycle at a time on the core clock.
`default_nettype none
module fifle_host (
  input  wire logic        i_core_clk,
  input  wire logic [31:0] i_rdata,
  input  wire logic        i_wait,
  output var  logic [7:0]  o_addr,
  output var  logic        o_rd,
  output var  logic        o_wr,
  output var  logic [31:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hang = 1'h0;  // Set if an answer never came
  initial begin
    {o_addr, o_rd, o_wr, o_wdata} = 42'h0;
  end
  // Raise on an edge, hold until waitrequest is seen low at a
  // rising edge, take read data at that edge, then release
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] v, output logic [31:0] r);
    int n;
    @(posedge i_core_clk);
    o_addr  <= a;
    o_wdata <= v;
    o_wr    <= w;
    o_rd    <= !w;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (i_wait && n < 40);
    hang |= i_wait;
    r = i_rdata;
    o_rd <= 1'h0;
    o_wr <= 1'h0;
  endtask : xfer
endmodule : fifle_host
`default_nettype wire

//--- test/fifle_top_properties.sv
// Port checker for the fast input block, bound to its top module.
// Assumes a short blink period handed down as FLASH_CYC.
`default_nettype none
module fifle_props #(parameter int FLASH_CYC = 8) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_bus_fault,
  input wire logic i_int_fault,
  input wire logic i_sensor_low,
  input wire logic i_tblock_present,
  input wire logic o_event_req,
  input wire logic o_lamp_err,
  input wire logic o_lamp_run,
  input wire logic o_lamp_io
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM = 2 * FLASH_CYC + 4;  // Longest wait for a blink edge
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // Bus answer: exactly one wait cycle
  wait_hi_a: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
    else $error("No wait cycle on new request");
  wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("Wait lasted too long");
  // Lamps; 8 cycles cover sync and register latency
  int_err_a: assert property (i_int_fault [*8] |-> o_lamp_err && !o_lamp_run)
    else $error("Internal fault lamps wrong");
  run_ok_a: assert property (!i_int_fault [*8] |-> o_lamp_run)
    else $error("Healthy lamp off");
  quiet_err_a: assert property (!(i_bus_fault || i_int_fault) [*8] |-> !o_lamp_err)
    else $error("Fault lamp without fault");
  bus_blink_a: assert property ((i_bus_fault && !i_int_fault) [*8]
    |-> ##[0:LIM] $changed(o_lamp_err)) else $error("Fault lamp not flashing");
  sens_io_a: assert property (i_sensor_low [*8] |-> o_lamp_io)
    else $error("Process lamp off on low supply");
  tb_blink_a: assert property ((!i_tblock_present && !i_sensor_low) [*8]
    |-> ##[0:LIM] $changed(o_lamp_io)) else $error("Process lamp not flashing");
  // Main scenarios reached
  cover property (o_event_req);
  cover property (i_bus_fault && o_lamp_err);
  cover property (i_avs_read && !o_avs_waitrequest);
endmodule : fifle_props
bind fifle_top fifle_props #(.FLASH_CYC(FLASH_CYC)) u_props (.*);
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the fast input filter, latch and event block.
// Assumes the host model on the bus and short tick and blink counts.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] e;} fifle_row_t;
  fifle_row_t  rows [9] = '{'{8'h00, 32'h10}, '{8'h04, 32'h0}, '{8'h08, 32'h0},
    '{8'h0c, 32'h0}, '{8'h10, 32'h0}, '{8'h14, 32'h0}, '{8'h40, 32'h0},
    '{8'h7c, 32'hf}, '{8'h30, 32'h0}};  // Reset values, unmapped last
  logic        clk, rst_b, rd, wr, wq, bf, inf, sl, tbp, evq;
  logic [15:0] din;
  logic [7:0]  adr;
  logic [31:0] wd, rdat, d;
  int          error_cnt = 0;
  int          cmp_count = 0;
  fifle_top #(.TICK_CYC(4), .FLASH_CYC(8)) dut (.i_core_clk(clk), .i_rst_b(rst_b),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdat), .o_avs_waitrequest(wq),
    .i_din(din), .i_bus_fault(bf), .i_int_fault(inf), .i_sensor_low(sl),
    .i_tblock_present(tbp), .o_event_req(evq), .o_lamp_err(), .o_lamp_run(),
    .o_lamp_io());
  fifle_host host (.i_core_clk(clk), .i_rdata(rdat), .i_wait(wq), .o_addr(adr),
    .o_rd(rd), .o_wr(wr), .o_wdata(wd));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Verdict and end of run
  task automatic conclude;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // Word compare; a hung bus also counts
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (host.hang || g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
    if (host.hang) conclude();
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'h0, a, 32'h0, d);
    chk(d, e);
  endtask : rchk
  task automatic wr32(input logic [7:0] a, input logic [31:0] v);
    host.xfer(1'h1, a, v, d);
  endtask : wr32
  initial begin
    rst_b = 1'h0;
    {din, bf, inf, sl, tbp} = 20'h1;
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) rchk(rows[i].a, rows[i].e);
    wr32(8'h00, 32'he);  // Filter write outside configuration
    rchk(8'h00, 32'h10);
    wr32(8'h00, 32'h1);  // Enter configuration first
    wr32(8'h00, 32'hf);  // 3.5 ms for contacts
    rchk(8'h00, 32'hf);
    wr32(8'h04, 32'h0002_0002);  // Latch ch1 on 0 to 1
    wr32(8'h08, 32'hc);  // Events on ch2, ch3
    wr32(8'h0c, 32'hd0);  // ch2 rising, ch3 either edge
    wr32(8'h48, 32'h5);  // Handler 5 in range
    wr32(8'h4c, 32'h0);  // Zero refused off ch0
    rchk(8'h4c, 32'h3);
    wr32(8'h48, 32'h40);  // Index above range refused
    rchk(8'h48, 32'h5);
    din[0] <= 1'h1;
    repeat (100) @(posedge clk);
    rchk(8'h10, 32'h0);
    repeat (80) @(posedge clk);
    rchk(8'h10, 32'h1);
    din[1] <= 1'h1;  // Pulse outlasts filter
    repeat (200) @(posedge clk);
    din[1] <= 1'h0;
    repeat (200) @(posedge clk);
    chk({31'h0, evq}, 32'h0);
    rchk(8'h10, 32'h3);
    rchk(8'h10, 32'h1);
    din[3:2] <= 2'h3;  // Same edge on two channels
    repeat (200) @(posedge clk);
    chk({31'h0, evq}, 32'h1);
    rchk(8'h18, 32'h8005_0102);
    rchk(8'h18, 32'h8003_0103);
    @(posedge clk);
    chk({31'h0, evq}, 32'h0);
    din[3:2] <= 2'h0;  // Both fall together; ch2 set for rising only
    repeat (200) @(posedge clk);
    rchk(8'h18, 32'h8003_0003);
    wr32(8'h04, 32'h0000_0002);  // Latch ch1 on 1 to 0
    din[1] <= 1'h1;
    repeat (200) @(posedge clk);
    din[1] <= 1'h0;
    repeat (200) @(posedge clk);
    din[1] <= 1'h1;
    repeat (200) @(posedge clk);
    rchk(8'h10, 32'h1);
    rchk(8'h10, 32'h3);
    sl <= 1'h1;
    repeat (20) @(posedge clk);
    rchk(8'h14, 32'hffff_0004);
    rchk(8'h10, 32'h0);
    {bf, inf, tbp} <= 3'h6;
    repeat (40) @(posedge clk);
    rchk(8'h14, 32'hffff_000f);
    {inf, sl} <= 2'h0;  // Let both lamps flash
    repeat (40) @(posedge clk);
    wr32(8'h00, 32'h8000_0001);  // Restore filter default, stay in config
    rchk(8'h00, 32'h11);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    rchk(8'h00, 32'h10);
    conclude();
  end
endmodule : testbench
`default_nettype wire
